// File: inc/sdf_pkg.sv
// Shared constants, layouts and types for the storage command interpreter
package sdf_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int NBLK = 16;
    localparam int IDXW = 4;
    localparam logic [63:0] BLK_BYTES = 64'h0000_0000_0000_0004;
    // ****************************************
    // Opcodes, arbitrary encoding
    // ****************************************
    localparam logic [7:0] OP_FLUSH = 8'h00;
    localparam logic [7:0] OP_WRITE = 8'h01;
    localparam logic [7:0] OP_READ = 8'h02;
    localparam logic [7:0] OP_COMPARE = 8'h05;
    localparam logic [7:0] OP_DSM = 8'h09;
    localparam logic [7:0] OP_SANITIZE = 8'h84;
    // ****************************************
    // Status codes
    // ****************************************
    localparam logic [2:0] SCT_GENERIC = 3'h0;
    localparam logic [2:0] SCT_CMD = 3'h1;
    localparam logic [2:0] SCT_MEDIA = 3'h2;
    localparam logic [7:0] SC_OK = 8'h00;
    localparam logic [7:0] SC_BAD_OPCODE = 8'h01;
    localparam logic [7:0] SC_LBA_RANGE = 8'h80;
    localparam logic [7:0] SC_CONFLICT = 8'h80;
    localparam logic [7:0] SC_RO_RANGE = 8'h82;
    localparam logic [7:0] SC_COMPARE_FAIL = 8'h85;
    localparam logic [7:0] SC_UNWRITTEN = 8'h87;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int DW12_RETRY = 31;
    localparam int DW12_FORCE = 30;
    localparam int DW12_PRI_HI = 29;
    localparam int DW12_PRI_LO = 26;
    localparam int DW12_CNT_HI = 15;
    localparam int DSM_DEALLOC = 2;
    localparam int DSM_WPREP = 10;
    // ****************************************
    // Returned values for unallocated blocks, and the guard CRC polynomial
    // ****************************************
    localparam logic [31:0] FILL_WORD = 32'h0000_0000;
    localparam logic [15:0] PI_GUARD_NONE = 16'hFFFF;
    localparam logic [15:0] PI_APP_NONE = 16'hFFFF;
    localparam logic [31:0] PI_REF_NONE = 32'hFFFF_FFFF;
    localparam logic [15:0] CRC_POLY = 16'h8BB7;
    // ****************************************
    // Register map and reset values
    // ****************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_RO_MASK = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_BLK_MAP = 8'h0C;
    localparam int CTRL_ERR_EN = 0;
    localparam int CTRL_RO_EN = 1;
    localparam logic RST_ERR_EN = 1'b0;
    localparam logic RST_RO_EN = 1'b0;
    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic [7:0] opcode;
        logic [15:0] cid;
        logic [15:0] cq_id;
        logic [63:0] metadata_pointer;
        logic [127:0] data_buffer_pointer;
        logic [31:0] dw10;
        logic [31:0] dw11;
        logic [31:0] dw12;
        logic [31:0] dw13;
    } sdf_cmd_s;
    typedef struct packed {
        logic valid;
        logic [15:0] cid;
        logic [15:0] cq_id;
        logic [2:0] sct;
        logic [7:0] sc;
    } sdf_cpl_s;
    typedef struct packed {
        logic valid;
        logic [63:0] lba;
        logic [63:0] dest;
        logic [63:0] meta;
        logic [31:0] data;
        logic [15:0] guard;
        logic [15:0] app_tag;
        logic [31:0] ref_tag;
        logic limited_retry_flag;
        logic forced_media_access_flag;
        logic [3:0] protection_action_field;
    } sdf_rdat_s;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01
    } sdf_st_e;
endpackage

// File: src/sdf_core.sv
// Storage command interpreter: deallocate, dataset management, flush, read
// ****************************************
// Notes on behaviour
// ****************************************
// Notes on behaviour
// - Write clears deallocation; reads never change it
// - Deallocated reads repeat until next write
// - Deallocated data reads fixed fill pattern
// - Sanitize wipes every older written value
// - Unwritten guard reads FFFFh or data CRC
// - Unwritten app tag FFFFh, ref tag ones
// - Enabled unwritten error fails read or compare
// - Dataset command posts completion to its queue
// - Conflicting dataset attributes give status 80h
// - Deallocate of read-only range gives 82h
// - Flush commits data to nonvolatile media
// - Flush covers commands completed before it
// - Flush fields reserved; completion posted
// - Read uses dwords ten to fifteen; code decodes ten to twelve
// - Decode metadata and data buffer pointers
// - Start block from dword 10 and 11
// - Limited retry bit 31 steers recovery
// - Forced access bit 30 reads from media
// - Protection action bits 29:26, rest reserved
// - Block count zero based, plus one
`timescale 1ns/1ps
module sdf_core
    import sdf_pkg::*;
(
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic CMD_VALID_I,
    input wire sdf_cmd_s CMD_I,
    output logic CMD_READY_O,
    output sdf_cpl_s CPL_O,
    output sdf_rdat_s RDAT_O,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [31:0] REG_RDATA_O,
    output logic [NBLK-1:0] MEDIA_DIRTY_O
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        sdf_st_e st;
        logic ready;
        sdf_cpl_s cpl;
        sdf_rdat_s rdat;
        logic [31:0] rdata;
        logic [63:0] lba;
        logic [16:0] remain;
        logic [63:0] dest;
        logic retry;
        logic force_acc;
        logic [3:0] pri;
        logic [NBLK-1:0][31:0] data;
        logic [NBLK-1:0] dealloc;
        logic [NBLK-1:0] written;
        logic [NBLK-1:0] dirty;
        logic err_en;
        logic ro_en;
        logic [NBLK-1:0] ro_mask;
        logic [15:0] flush_cnt;
    } sdf_state_s;

    sdf_state_s s_ff;
    sdf_state_s nxt_s;

    // ****************************************
    // Command decode
    // ****************************************
    logic [63:0] cmd_lba;
    logic [63:0] cmd_last;
    logic [16:0] cmd_cnt;
    logic range_bad;
    logic [NBLK-1:0] in_rng;
    logic [NBLK-1:0] cmp_ok;

    assign cmd_lba = {CMD_I.dw11, CMD_I.dw10};
    assign cmd_cnt = {1'b0, CMD_I.dw12[DW12_CNT_HI:0]} + 17'h0_0001;
    assign cmd_last = cmd_lba + {48'h0, CMD_I.dw12[DW12_CNT_HI:0]};
    // Wrap of the 64-bit sum is caught as out of range too
    assign range_bad = (cmd_last >= 64'(NBLK)) || (cmd_last < cmd_lba);

    generate
        for (genvar i = 0; i < NBLK; i++) begin : g_blk
            assign in_rng[i] = (64'(i) >= cmd_lba) && (64'(i) <= cmd_last);
            assign cmp_ok[i] = !in_rng[i] || (s_ff.data[i] == CMD_I.dw13);
        end
    endgenerate

    // Guard over the returned word; any CRC of the data is permitted
    function automatic logic [15:0] crc16(input logic [31:0] d);
        logic [15:0] c;
        c = 16'h0000;
        for (int b = 31; b >= 0; b--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[b]) ? CRC_POLY : 16'h0000);
        end
        return c;
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    logic [IDXW-1:0] idx;
    logic blank;

    assign idx = s_ff.lba[IDXW-1:0];
    assign blank = s_ff.dealloc[idx] || !s_ff.written[idx];

    always_comb begin
        nxt_s = s_ff;
        nxt_s.cpl.valid = 1'b0;
        nxt_s.rdat.valid = 1'b0;
        nxt_s.rdata = 32'h0000_0000;
        case (s_ff.st)
            ST_IDLE: begin
                if (CMD_VALID_I && s_ff.ready) begin
                    nxt_s.cpl.valid = 1'b1;
                    nxt_s.cpl.cid = CMD_I.cid;
                    nxt_s.cpl.cq_id = CMD_I.cq_id;
                    nxt_s.cpl.sct = SCT_GENERIC;
                    nxt_s.cpl.sc = SC_OK;
                    if (CMD_I.opcode == OP_FLUSH) begin
                        // Commands run one at a time, so all earlier ones are done
                        nxt_s.dirty = '0;
                        nxt_s.flush_cnt = s_ff.flush_cnt + 16'h0001;
                    end else if (CMD_I.opcode == OP_SANITIZE) begin
                        nxt_s.data = '0;
                        nxt_s.written = '0;
                        nxt_s.dealloc = '0;
                        nxt_s.dirty = '0;
                    end else if (CMD_I.opcode == OP_DSM && CMD_I.dw13[DSM_DEALLOC]
                            && CMD_I.dw13[DSM_WPREP]) begin
                        // Conflict outranks a bad range so the code stays specific
                        nxt_s.cpl.sct = SCT_CMD;
                        nxt_s.cpl.sc = SC_CONFLICT;
                    end else if (range_bad && (CMD_I.opcode == OP_WRITE
                            || CMD_I.opcode == OP_READ || CMD_I.opcode == OP_COMPARE
                            || CMD_I.opcode == OP_DSM)) begin
                        nxt_s.cpl.sc = SC_LBA_RANGE;
                    end else if (CMD_I.opcode == OP_WRITE) begin
                        for (int i = 0; i < NBLK; i++) begin
                            if (in_rng[i]) begin
                                nxt_s.data[i] = CMD_I.dw13;
                                nxt_s.dealloc[i] = 1'b0;
                                nxt_s.written[i] = 1'b1;
                                nxt_s.dirty[i] = 1'b1;
                            end
                        end
                    end else if (CMD_I.opcode == OP_READ || CMD_I.opcode == OP_COMPARE) begin
                        if (s_ff.err_en && |(in_rng & (s_ff.dealloc | ~s_ff.written))) begin
                            nxt_s.cpl.sct = SCT_MEDIA;
                            nxt_s.cpl.sc = SC_UNWRITTEN;
                        end else if (CMD_I.opcode == OP_COMPARE) begin
                            if (!(&cmp_ok)) begin
                                nxt_s.cpl.sct = SCT_MEDIA;
                                nxt_s.cpl.sc = SC_COMPARE_FAIL;
                            end
                        end else begin
                            // Completion waits for the last block
                            nxt_s.cpl.valid = 1'b0;
                            nxt_s.st = ST_READ;
                            nxt_s.lba = cmd_lba;
                            nxt_s.remain = cmd_cnt;
                            nxt_s.dest = CMD_I.data_buffer_pointer[63:0];
                            nxt_s.rdat.meta = CMD_I.metadata_pointer;
                            nxt_s.retry = CMD_I.dw12[DW12_RETRY];
                            nxt_s.force_acc = CMD_I.dw12[DW12_FORCE];
                            nxt_s.pri = CMD_I.dw12[DW12_PRI_HI:DW12_PRI_LO];
                            if (CMD_I.dw12[DW12_FORCE]) begin
                                // Range goes to media before it is returned
                                nxt_s.dirty = s_ff.dirty & ~in_rng;
                            end
                        end
                    end else if (CMD_I.opcode == OP_DSM) begin
                        if (CMD_I.dw13[DSM_DEALLOC] && s_ff.ro_en
                                && |(in_rng & s_ff.ro_mask)) begin
                            nxt_s.cpl.sct = SCT_CMD;
                            nxt_s.cpl.sc = SC_RO_RANGE;
                        end else if (CMD_I.dw13[DSM_DEALLOC]) begin
                            nxt_s.dealloc = s_ff.dealloc | in_rng;
                        end
                    end else begin
                        nxt_s.cpl.sc = SC_BAD_OPCODE;
                    end
                end
            end
            ST_READ: begin
                nxt_s.rdat.valid = 1'b1;
                nxt_s.rdat.lba = s_ff.lba;
                nxt_s.rdat.dest = s_ff.dest;
                nxt_s.rdat.limited_retry_flag = s_ff.retry;
                nxt_s.rdat.forced_media_access_flag = s_ff.force_acc;
                nxt_s.rdat.protection_action_field = s_ff.pri;
                if (blank) begin
                    // Fixed fill keeps repeated reads identical
                    nxt_s.rdat.data = FILL_WORD;
                    nxt_s.rdat.guard = PI_GUARD_NONE;
                    nxt_s.rdat.app_tag = PI_APP_NONE;
                    nxt_s.rdat.ref_tag = PI_REF_NONE;
                end else begin
                    nxt_s.rdat.data = s_ff.data[idx];
                    nxt_s.rdat.guard = crc16(s_ff.data[idx]);
                    nxt_s.rdat.app_tag = 16'h0000;
                    nxt_s.rdat.ref_tag = s_ff.lba[31:0];
                end
                nxt_s.lba = s_ff.lba + 64'h1;
                nxt_s.dest = s_ff.dest + BLK_BYTES;
                nxt_s.remain = s_ff.remain - 17'h0_0001;
                if (s_ff.remain == 17'h0_0001) begin
                    nxt_s.st = ST_IDLE;
                    nxt_s.cpl.valid = 1'b1;
                end
            end
            default: begin
                nxt_s.st = ST_IDLE;
            end
        endcase
        // ****************************************
        // Register port
        // ****************************************
        if (REG_WR_I) begin
            if (REG_ADDR_I == REG_CTRL) begin
                nxt_s.err_en = REG_WDATA_I[CTRL_ERR_EN];
                nxt_s.ro_en = REG_WDATA_I[CTRL_RO_EN];
            end else if (REG_ADDR_I == REG_RO_MASK) begin
                nxt_s.ro_mask = REG_WDATA_I[NBLK-1:0];
            end
        end
        if (REG_RD_I) begin
            if (REG_ADDR_I == REG_CTRL) begin
                nxt_s.rdata = {30'h0, s_ff.ro_en, s_ff.err_en};
            end else if (REG_ADDR_I == REG_RO_MASK) begin
                nxt_s.rdata = {16'h0, s_ff.ro_mask};
            end else if (REG_ADDR_I == REG_STATUS) begin
                nxt_s.rdata = {s_ff.flush_cnt, 15'h0, s_ff.st == ST_READ};
            end else if (REG_ADDR_I == REG_BLK_MAP) begin
                nxt_s.rdata = {s_ff.written, s_ff.dealloc};
            end
        end
        nxt_s.ready = (nxt_s.st == ST_IDLE);
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            s_ff <= '0;
            s_ff.st <= ST_IDLE;
            s_ff.ready <= 1'b1;
            s_ff.err_en <= RST_ERR_EN;
            s_ff.ro_en <= RST_RO_EN;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign CMD_READY_O = s_ff.ready;
    assign CPL_O = s_ff.cpl;
    assign RDAT_O = s_ff.rdat;
    assign REG_RDATA_O = s_ff.rdata;
    assign MEDIA_DIRTY_O = s_ff.dirty;
endmodule

// File: test/sdf_core_properties.sv
// Port checks for the storage command interpreter
`timescale 1ns/1ps
module sdf_core_properties
    import sdf_pkg::*;
(
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic CMD_VALID_I,
    input wire sdf_cmd_s CMD_I,
    input wire logic CMD_READY_O,
    input wire sdf_cpl_s CPL_O,
    input wire sdf_rdat_s RDAT_O,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [31:0] REG_RDATA_O,
    input wire logic [NBLK-1:0] MEDIA_DIRTY_O
);
    // ******
    // Checks
    // ******
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);
    logic take;
    assign take = CMD_VALID_I && CMD_READY_O;
    // First block of a read shows two edges after the take
    sequence rd_first;
        take && CMD_I.opcode == OP_READ ##2 RDAT_O.valid;
    endsequence
    AST_START: assert property (rd_first |-> RDAT_O.lba == $past({CMD_I.dw11, CMD_I.dw10}, 2))
        else $error("Start block differs from command");
    AST_DW12: assert property (rd_first |-> {RDAT_O.limited_retry_flag,
        RDAT_O.forced_media_access_flag, RDAT_O.protection_action_field} == $past(CMD_I.dw12[31:26], 2))
        else $error("Read flags differ from command");
    AST_COUNT: assert property (take && CMD_I.opcode == OP_READ && CMD_I.dw12[15:0] == 16'h0001
        ##2 RDAT_O.valid |-> !CPL_O.valid ##1 (RDAT_O.valid && CPL_O.valid))
        else $error("Two block read not two beats");
    // Ready stays low while beats remain and returns with the last one
    AST_BUSY: assert property (RDAT_O.valid |-> CMD_READY_O == CPL_O.valid)
        else $error("Ready wrong during read beats");
    AST_TAGS: assert property (RDAT_O.valid && RDAT_O.app_tag != 16'h0000 |->
        RDAT_O.app_tag == PI_APP_NONE && RDAT_O.ref_tag == PI_REF_NONE) else $error("Bad tags");
    AST_GUARD: assert property (RDAT_O.valid && RDAT_O.app_tag == PI_APP_NONE |->
        RDAT_O.guard == PI_GUARD_NONE || RDAT_O.guard == 16'h0000 && RDAT_O.data == 32'h0000_0000)
        else $error("Bad guard on unwritten block");
    AST_DSM: assert property (take && CMD_I.opcode == OP_DSM |=> CPL_O.valid &&
        CPL_O.cq_id == $past(CMD_I.cq_id) && CPL_O.cid == $past(CMD_I.cid))
        else $error("Dataset completion missing");
    AST_CONFLICT: assert property (take && CMD_I.opcode == OP_DSM && CMD_I.dw13[DSM_DEALLOC]
        && CMD_I.dw13[DSM_WPREP] |=> CPL_O.sct == SCT_CMD && CPL_O.sc == SC_CONFLICT)
        else $error("Conflict status missing");
    AST_FLUSH: assert property (take && CMD_I.opcode == OP_FLUSH |=> CPL_O.valid &&
        CPL_O.sc == SC_OK && MEDIA_DIRTY_O == '0) else $error("Flush left dirty blocks");
    cover property (rd_first ##1 RDAT_O.valid);
    cover property (take && CMD_I.opcode == OP_DSM ##1 CPL_O.sc == SC_RO_RANGE);
    cover property (take && CMD_I.opcode == OP_FLUSH);
endmodule
bind sdf_core sdf_core_properties sdf_core_properties_inst (.CLK_I(CLK_I),
    .ARST_N_I(ARST_N_I), .CMD_VALID_I(CMD_VALID_I), .CMD_I(CMD_I), .CMD_READY_O(CMD_READY_O),
    .CPL_O(CPL_O), .RDAT_O(RDAT_O), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
    .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
    .MEDIA_DIRTY_O(MEDIA_DIRTY_O));

// File: test/sdf_host_model.sv
// Host side model offering commands to the interpreter
`timescale 1ns/1ps
module sdf_host_model
    import sdf_pkg::*;
(
    input wire logic clk_i,
    input wire logic ready_i,
    output logic cmd_valid_o,
    output sdf_cmd_s cmd_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = '0;
    end
    // Offer held until an edge with ready high takes it, or dropped after 64 falling edges without ready
    task automatic send(input sdf_cmd_s c, output bit ok);
        ok = 1'b0;
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_o <= c;
        for (int i = 0; i < 64 && !ok; i++) begin
            @(negedge clk_i);
            ok = ready_i;
        end
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        // Released fields show junk, never the last command
        cmd_o <= ~c;
    endtask
endmodule

// File: test/tb.sv
// Self-checking bench for the storage command interpreter
`timescale 1ns/1ps
module tb;
    import sdf_pkg::*;
    localparam logic [63:0] DBUF = 64'h0000_0000_0000_9000;
    logic clk, arst_n, cmd_valid, ready, reg_wr, reg_rd;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, rdata;
    logic [15:0] dirty;
    logic [63:0] base;
    sdf_cmd_s cmd;
    sdf_cpl_s cpl, got_cpl;
    sdf_rdat_s rdat;
    sdf_rdat_s rq[$];
    int checks, err_count, cpl_n;
    sdf_core sdf_core_inst (.CLK_I(clk), .ARST_N_I(arst_n), .CMD_VALID_I(cmd_valid), .CMD_I(cmd),
        .CMD_READY_O(ready), .CPL_O(cpl), .RDAT_O(rdat), .REG_ADDR_I(reg_addr),
        .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(rdata),
        .MEDIA_DIRTY_O(dirty));
    sdf_host_model sdf_host_model_inst (.clk_i(clk), .ready_i(ready), .cmd_valid_o(cmd_valid),
        .cmd_o(cmd));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rdat.valid === 1'b1) rq.push_back(rdat);
        if (cpl.valid === 1'b1) begin
            got_cpl <= cpl;
            cpl_n <= cpl_n + 1;
        end
    end
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic acc(input bit w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= wd;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge clk);
        {reg_wr, reg_rd} <= 2'b00;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic run(input logic [7:0] op, input int lba, input int block_count_field, input int hi,
        input int d13, input logic [2:0] xs = SCT_GENERIC, input logic [7:0] xsc = SC_OK);
        sdf_cmd_s c;
        int n0;
        bit ok;
        c = '0;
        c.opcode = op;
        c.cid = 16'(lba) ^ 16'h5A00;
        c.cq_id = 16'h0007;
        if (op != OP_FLUSH) begin
            c.metadata_pointer = 64'h0000_0000_0000_4000;
            c.data_buffer_pointer = {64'h0, DBUF};
            c.dw10 = 32'(lba);
            c.dw12 = {16'(hi), 16'(block_count_field)};
            c.dw13 = 32'(d13);
        end
        base = 64'(lba);
        rq.delete();
        n0 = cpl_n;
        sdf_host_model_inst.send(c, ok);
        for (int i = 0; i < 40 && cpl_n == n0; i++) @(negedge clk);
        if (!ok || cpl_n == n0) begin
            err_count++;
            conclude();
        end
        chk({got_cpl.sct, got_cpl.sc}, {xs, xsc});
        chk({got_cpl.cid, got_cpl.cq_id}, {c.cid, c.cq_id});
    endtask
    // Unwritten blocks carry the skip-check tags
    task automatic blk(input int i, input logic [31:0] d, input bit unw);
        chk(rq[i].data, d);
        chk(rq[i].lba, base + 64'(i));
        chk(rq[i].dest, DBUF + 64'(4 * i));
        chk(rq[i].app_tag, unw ? PI_APP_NONE : 16'h0000);
        chk(rq[i].ref_tag, unw ? PI_REF_NONE : 32'(base + 64'(i)));
        if (unw) chk(rq[i].guard, PI_GUARD_NONE);
    endtask
    task automatic done(input string s);
        $display("Test %s ended: checks %0d mismatches %0d", s, checks, err_count);
    endtask
    task automatic conclude();
        $display("Totals: checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        logic [31:0] d;
        {arst_n, reg_wr, reg_rd} = 3'b000;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        acc(1'b0, REG_CTRL, 32'h0, d);
        chk(d, 32'h0);
        acc(1'b0, 8'h20, 32'h0, d);
        chk(d, 32'h0);
        // Flags and reserved bits set together
        run(OP_READ, 3, 1, 16'hE802, 0);
        chk(rq.size(), 2);
        blk(0, 32'h0, 1'b1);
        blk(1, 32'h0, 1'b1);
        chk({rq[0].limited_retry_flag, rq[0].forced_media_access_flag}, 2'b11);
        chk(rq[0].protection_action_field, 4'hA);
        chk(rq[0].meta, 64'h0000_0000_0000_4000);
        run(OP_READ, 15, 1, 0, 0, SCT_GENERIC, SC_LBA_RANGE);
        done("unwritten read");
        run(OP_WRITE, 3, 1, 0, 32'hCAFE_0001);
        chk(dirty, 16'h0018);
        run(OP_DSM, 3, 0, 0, 32'h4);
        acc(1'b0, REG_BLK_MAP, 32'h0, d);
        chk(d, 32'h0018_0008);
        run(OP_READ, 3, 1, 0, 0);
        blk(0, 32'h0, 1'b1);
        blk(1, 32'hCAFE_0001, 1'b0);
        run(OP_READ, 3, 0, 0, 0);
        blk(0, 32'h0, 1'b1);
        run(OP_WRITE, 3, 0, 0, 32'h0000_1234);
        run(OP_READ, 3, 0, 0, 0);
        blk(0, 32'h0000_1234, 1'b0);
        done("deallocate");
        run(OP_DSM, 3, 0, 0, 32'h404, SCT_CMD, SC_CONFLICT);
        run(OP_DSM, 15, 1, 0, 32'h404, SCT_CMD, SC_CONFLICT);
        acc(1'b1, REG_RO_MASK, 32'h10, d);
        acc(1'b1, REG_CTRL, 32'h2, d);
        run(OP_DSM, 4, 0, 0, 32'h4, SCT_CMD, SC_RO_RANGE);
        run(OP_READ, 4, 0, 0, 0);
        blk(0, 32'hCAFE_0001, 1'b0);
        done("dataset status");
        run(OP_FLUSH, 0, 0, 0, 0);
        chk(dirty, 16'h0000);
        acc(1'b0, REG_STATUS, 32'h0, d);
        chk(d, 32'h0001_0000);
        run(8'h7F, 0, 0, 0, 0, SCT_GENERIC, SC_BAD_OPCODE);
        done("flush");
        acc(1'b1, REG_CTRL, 32'h1, d);
        run(OP_READ, 2, 1, 0, 0, SCT_MEDIA, SC_UNWRITTEN);
        chk(rq.size(), 0);
        run(OP_COMPARE, 5, 0, 0, 0, SCT_MEDIA, SC_UNWRITTEN);
        run(OP_COMPARE, 3, 0, 0, 32'h1234);
        run(OP_COMPARE, 3, 0, 0, 32'h1235, SCT_MEDIA, SC_COMPARE_FAIL);
        done("unwritten error");
        run(OP_SANITIZE, 0, 0, 0, 0);
        acc(1'b1, REG_CTRL, 32'h0, d);
        run(OP_READ, 3, 1, 0, 0);
        blk(0, 32'h0, 1'b1);
        blk(1, 32'h0, 1'b1);
        done("sanitize");
        conclude();
    end
endmodule
